// file: src/rsc_counter.sv
/*
 * real-time counter (three chained 12-bit sections, ring-sequenced read,
 * slow-clock buffer on the low section) and a one-section sample rate
 * counter with reload and overflow interrupt.
 * assumes timing triplicates and instruction strobes are synchronous to
 * sys_clk and that a word is 12 shift-clock pulses between word strobes.
 */
`default_nettype none
// Overview of operation
// - section increments once per word when enabled
// - low count-enable clears incrementing control flop
// - carry-out only when all ones roll over
// - higher section enabled by lower section carry
// - lowest section count-enable tied high
// - buffer loads section count every word-time
// - real-time counter chains three 12-bit sections
// - read returns ringed section, ring advances
// - output instruction resets ring to lowest section
// - overflow at strobe reloads sample counter
// - overflow sets interrupt flip-flop
// - output instruction clears interrupt flip-flop
// - input instruction also reloads sample counter
// - timing inputs majority voted two of three
module rsc_counter
	import rsc_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	input  wire logic [2:0]               shift_clock_pulse,
	input  wire logic [2:0]               word_strobe_pulse,
	input  wire logic                     rtc_input_instruction,
	input  wire logic                     rtc_output_instruction,
	input  wire logic                     src_input_instruction,
	input  wire logic                     src_output_instruction,
	input  wire logic [SEC_W-1:0]         src_reload_value,
	output logic      [SEC_W-1:0]         rtc_read_data,
	output logic      [RTC_SECS-1:0]      rtc_ring,
	output logic      [SEC_W-1:0]         rtc_slow_clocks,
	output logic      [SEC_W*RTC_SECS-1:0] rtc_count,
	output logic      [SEC_W-1:0]         src_count,
	output logic                          src_irq
);
	function automatic logic vote3(input logic [2:0] v);
		return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	logic sc;
	logic ws;
	assign sc = vote3(shift_clock_pulse);
	assign ws = vote3(word_strobe_pulse);

	// sections 0..2 are real-time, section 3 is the sample rate counter
	localparam int NS = RTC_SECS + SRC_SECS;
	logic [SEC_W-1:0] sh_r [NS];
	logic [NS-1:0]    inc_r;
	logic [NS-1:0]    cy_r;
	logic [NS-1:0]    en;
	logic [NS-1:0]    ovf;
	logic [RTC_SECS-1:0] ring_r;
	logic [SEC_W-1:0] slow_r;
	logic [SEC_W-1:0] rd_r;
	logic             irq_r;
	logic             reload;

	// carry-out: carry flop still holds one at strobe only after all-ones wrap
	assign ovf = cy_r & inc_r;
	assign en[0] = 1'b1;
	assign en[RTC_SECS] = 1'b1;
	assign reload = (ws & ovf[RTC_SECS]) | src_input_instruction;

	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_sec
			if (g != 0 && g != RTC_SECS) begin : g_chain
				assign en[g] = ovf[g-1];
			end
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					sh_r[g] <= SEC_RST;
					cy_r[g] <= 1'b0;
					inc_r[g] <= 1'b0;
				end else if (g == RTC_SECS && reload) begin
					sh_r[g] <= src_reload_value;
					cy_r[g] <= 1'b0;
					inc_r[g] <= 1'b0;
				end else if (ws) begin
					inc_r[g] <= en[g];
					cy_r[g] <= en[g];
				end else if (sc) begin
					// serial add, lsb first, carry rides along
					sh_r[g] <= {sh_r[g][0] ^ cy_r[g], sh_r[g][SEC_W-1:1]};
					cy_r[g] <= sh_r[g][0] & cy_r[g];
				end
			end
		end
	endgenerate

	// slow-clock buffer on the low real-time section
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			slow_r <= SEC_RST;
		end else if (ws) begin
			slow_r <= sh_r[0];
		end
	end

	// read ring
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ring_r <= RING_RST;
			rd_r <= SEC_RST;
		end else if (rtc_output_instruction) begin
			ring_r <= RING_RST;
		end else if (rtc_input_instruction) begin
			ring_r <= {ring_r[RTC_SECS-2:0], ring_r[RTC_SECS-1]};
			rd_r <= (ring_r[0] ? sh_r[0] : SEC_RST)
				| (ring_r[1] ? sh_r[1] : SEC_RST)
				| (ring_r[2] ? sh_r[2] : SEC_RST);
		end
	end

	// interrupt: overflow set beats output-instruction clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_r <= 1'b0;
		end else if (ws && ovf[RTC_SECS]) begin
			irq_r <= 1'b1;
		end else if (src_output_instruction) begin
			irq_r <= 1'b0;
		end
	end

	assign rtc_read_data = rd_r;
	assign rtc_ring = ring_r;
	assign rtc_slow_clocks = slow_r;
	assign rtc_count = {sh_r[2], sh_r[1], sh_r[0]};
	assign src_count = sh_r[RTC_SECS];
	assign src_irq = irq_r;

	a_ring_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rtc_output_instruction |=> rtc_ring == RING_RST) else $error("ring not reset");
	a_ring_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rtc_input_instruction && !rtc_output_instruction
		|=> rtc_ring == {$past(ring_r[1:0]), $past(ring_r[2])}) else $error("ring not stepped");
	a_ring_onehot: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$onehot(ring_r)) else $error("ring not one-hot");
	a_irq_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ws && ovf[RTC_SECS] |=> src_irq) else $error("irq not set");
	a_irq_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
		src_output_instruction && !(ws && ovf[RTC_SECS]) |=> !src_irq)
		else $error("irq not cleared");
	a_src_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
		src_input_instruction |=> src_count == $past(src_reload_value))
		else $error("reload missed");
	a_ovf_ones: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ws && ovf[0] |-> sh_r[0] == SEC_RST) else $error("carry without wrap");
	a_disable_inc: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ws && !en[1] |=> !inc_r[1]) else $error("inc flop not cleared");
	a_low_inc: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ws |=> inc_r[0]) else $error("low section not counting");
	a_slow_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ws |=> rtc_slow_clocks == $past(sh_r[0])) else $error("buffer stale");
	a_chain: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ws |=> inc_r[2] == $past(ovf[1])) else $error("chain broken");
	a_vote: assert property (@(posedge sys_clk)
		sc == ((shift_clock_pulse[0] + shift_clock_pulse[1] + shift_clock_pulse[2]) >= 2))
		else $error("vote wrong");
	a_vote_ws: assert property (@(posedge sys_clk)
		ws == ((word_strobe_pulse[0] + word_strobe_pulse[1] + word_strobe_pulse[2]) >= 2))
		else $error("strobe vote wrong");

	// shift pulses seen since the last strobe; saturates at one word
	logic [BITCNT_W-1:0] sc_seen_r;
	// set once a strobe has opened a word, so the first strobe is not judged
	logic                word_open_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sc_seen_r <= '0;
		end else if (ws) begin
			sc_seen_r <= '0;
		end else if (sc && sc_seen_r != BITCNT_W'(SEC_W)) begin
			sc_seen_r <= sc_seen_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			word_open_r <= 1'b0;
		end else if (ws) begin
			word_open_r <= 1'b1;
		end
	end

	// a read that the ring carries out, not overridden by an output instruction
	sequence s_read_req;
		rtc_input_instruction && !rtc_output_instruction;
	endsequence

	// nothing that may touch the ring or the read latch this cycle
	sequence s_ring_quiet;
		!rtc_input_instruction && !rtc_output_instruction;
	endsequence

	// the sample counter wrapped during the word that ends here
	sequence s_src_wrap;
		ws && ovf[RTC_SECS];
	endsequence

	// a cycle with neither strobe nor shift pulse
	sequence s_no_timing;
		!ws && !sc;
	endsequence

	// a full word of shift pulses has passed since a strobe
	sequence s_word_done;
		ws && word_open_r && sc_seen_r == BITCNT_W'(SEC_W);
	endsequence

	// each read latches the section that the ring points at
	generate
		for (g = 0; g < RTC_SECS; g++) begin : g_rd_chk
			a_read_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
				s_read_req ##0 ring_r[g] |=> rtc_read_data == $past(sh_r[g]))
				else $error("wrong section read");
		end
	endgenerate

	// per-section serial arithmetic
	generate
		for (g = 0; g < NS; g++) begin : g_sec_chk
			localparam bit IS_SRC = (g == RTC_SECS);
			logic no_load;
			// only the sample counter section can be loaded mid-word
			assign no_load = !(IS_SRC && src_input_instruction);

			a_seed_carry: assert property (@(posedge sys_clk) disable iff (sys_rst)
				ws && !(IS_SRC && reload)
				|=> inc_r[g] == $past(en[g]) && cy_r[g] == $past(en[g]))
				else $error("carry not seeded at strobe");

			a_plain_rotate: assert property (@(posedge sys_clk) disable iff (sys_rst)
				sc && !ws && no_load && !cy_r[g]
				|=> sh_r[g] == {$past(sh_r[g][0]), $past(sh_r[g][SEC_W-1:1])})
				else $error("section altered without carry");

			a_carry_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
				sc && !ws && no_load && !sh_r[g][0] |=> !cy_r[g])
				else $error("carry passed a zero bit");

			a_sec_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
				s_no_timing ##0 no_load
				|=> $stable(sh_r[g]) && $stable(cy_r[g]) && $stable(inc_r[g]))
				else $error("section moved without timing");
		end
	endgenerate

	a_word_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_word_done |-> sh_r[0] == slow_r + 12'h001)
		else $error("low section did not step by one");

	a_slow_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!ws |=> $stable(rtc_slow_clocks))
		else $error("buffer moved between strobes");

	a_ring_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_ring_quiet |=> $stable(rtc_ring) && $stable(rtc_read_data))
		else $error("ring or read data moved");

	a_out_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rtc_input_instruction && rtc_output_instruction |=> $stable(rtc_read_data))
		else $error("read taken under output instruction");

	a_irq_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(ws && ovf[RTC_SECS]) && !src_output_instruction |=> $stable(src_irq))
		else $error("irq moved without cause");

	a_wrap_reload: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_src_wrap |=> src_count == $past(src_reload_value) && !inc_r[RTC_SECS])
		else $error("wrap did not reload");

	a_wrap_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_src_wrap |-> src_count == SEC_RST)
		else $error("sample overflow without wrap");

	a_chain_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ws |=> inc_r[1] == $past(ovf[0]))
		else $error("middle section not chained");

	a_top_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ws && !ovf[1] |=> !inc_r[2])
		else $error("top section counting unasked");
endmodule // rsc_counter
`default_nettype wire

// file: src/rsc_pkg.sv
/*
 * constants for the real-time and sample rate counter block.
 * assumes a single synchronous clock domain; timing pulses arrive as
 * voted triplicates from a central timing source.
 */
`default_nettype none
package rsc_pkg;
	localparam int SEC_W     = 12;
	localparam int RTC_SECS  = 3;
	localparam int SRC_SECS  = 1;
	localparam int BITCNT_W  = 4;
	localparam logic [SEC_W-1:0] SEC_RST = 12'h000;
	localparam logic [SEC_W-1:0] SEC_ONES = 12'hFFF;
	localparam logic [RTC_SECS-1:0] RING_RST = 3'h1;
endpackage
`default_nettype wire

// file: dv/rsc_partner.sv
/* word timing source for the counter: one word strobe, then twelve
   shift clocks, each in three copies; hold parks it between words */
`default_nettype none
module rsc_partner (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       hold,
	input  wire logic       glitch,
	output logic      [2:0] sc,
	output logic      [2:0] ws,
	output var int          words,
	output logic            idle
);
	timeunit 1ns;
	timeprecision 1ns;
	int         pos;
	logic [2:0] bad;
	always @(posedge clk) begin
		if (rst) begin
			pos <= 13;
			words <= 0;
		end else if (pos < 13 || !hold) begin
			pos <= (pos == 13) ? 0 : pos + 1;
			if (pos == 12) words <= words + 1;
		end
		bad <= glitch ? 3'h1 << ($urandom % 3) : 3'h0;
	end
	// at most one copy is wrong, so a two-of-three vote hides it
	assign ws = {3{pos == 0}} ^ bad;
	assign sc = {3{pos > 0 && pos < 13}} ^ bad;
	assign idle = pos == 13;
endmodule // rsc_partner
`default_nettype wire

// file: dv/rsc_counter_test.sv
/* self-checking bench for rsc_counter: drives the instructions and the
   reload value, and relies on rsc_partner for the word timing */
`default_nettype none
module rsc_counter_test;
	import rsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, sys_rst = 1, hold = 1, glitch = 0, due = 0, irq, idle;
	logic rin = 0, rout = 0, sin = 0, sout = 0;
	logic [SEC_W-1:0]          rld = 12'h000, rd, slow, scnt;
	logic [RTC_SECS-1:0]       ring;
	logic [SEC_W*RTC_SECS-1:0] cnt;
	logic [2:0]                sc, ws;
	int                        words, bad_count = 0, samples_checked = 0, sel_q[$];
	logic [SEC_W-1:0]          exp_q[$];
	always #10 sys_clk = ~sys_clk;
	rsc_partner u_far (.clk(sys_clk), .rst(sys_rst), .hold(hold), .glitch(glitch),
		.sc(sc), .ws(ws), .words(words), .idle(idle));
	rsc_counter dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .shift_clock_pulse(sc),
		.word_strobe_pulse(ws), .rtc_input_instruction(rin), .rtc_output_instruction(rout),
		.src_input_instruction(sin), .src_output_instruction(sout), .src_reload_value(rld),
		.rtc_read_data(rd), .rtc_ring(ring), .rtc_slow_clocks(slow), .rtc_count(cnt),
		.src_count(scnt), .src_irq(irq));
	task automatic complete_run();
		$display("mismatches %0d, checks %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(logic [SEC_W-1:0] seen, logic [SEC_W-1:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	function automatic logic [SEC_W-1:0] pick(int s);
		case (s)
			0: return rd;
			1: return slow;
			2: return scnt;
			3: return cnt[SEC_W-1:0];
			4: return {11'h000, irq};
			default: return {9'h000, ring};
		endcase
	endfunction
	// pulses {rin,rout,sin,sout} for one cycle and notes what to expect after it
	task automatic op(logic [3:0] p, int s, logic [SEC_W-1:0] v);
		{rin, rout, sin, sout} <= p;
		due <= s >= 0;
		if (s >= 0) begin
			sel_q.push_back(s);
			exp_q.push_back(v);
		end
		@(posedge sys_clk) #1;
	endtask
	task automatic run_words(int n);
		int t;
		t = words + n;
		due <= 0;
		hold <= 0;
		for (int i = 0; i < 20 * n + 40 && words < t; i++) @(posedge sys_clk) #1;
		hold <= 1;
		repeat (2) @(posedge sys_clk) #1;
		if (words != t) begin
			bad_count++;
			$display("[FAIL] %0t: word timing stalled", $time);
			complete_run();
		end
	endtask
	always @(posedge sys_clk) if (due) begin
		#2 check(pick(sel_q.pop_front()), exp_q.pop_front());
	end
	initial begin
		void'($urandom(32'h28dc9bc9));
		repeat (4) @(posedge sys_clk);
		#1 sys_rst <= 0;
		op(4'h0, 5, 12'h001);
		op(4'h0, 4, 12'h000);
		$display("test reset done");
		run_words(5);
		op(4'h0, 1, 12'h004);
		op(4'h8, 0, 12'h005);
		op(4'h8, 0, 12'h000);
		op(4'h4, 5, 12'h001);
		op(4'h8, 0, 12'h005);
		op(4'h0, -1, 12'h000);
		$display("test count and read done");
		rld = 12'hFF0 | SEC_W'($urandom % 16);
		op(4'h2, 2, 12'hFF0 | rld);
		op(4'h0, -1, 12'h000);
		run_words(4096 - int'(rld));
		op(4'h0, 2, 12'h000);
		op(4'h0, 4, 12'h000);
		run_words(1);
		op(4'h0, 2, rld);
		op(4'h0, 4, 12'h001);
		op(4'h1, 4, 12'h000);
		op(4'h0, -1, 12'h000);
		$display("test sample counter done");
		glitch <= 1;
		run_words(4100 - words);
		op(4'h0, 3, 12'h004);
		op(4'h4, -1, 12'h000);
		op(4'h8, 0, 12'h004);
		op(4'h8, 0, 12'h001);
		op(4'h8, 0, 12'h000);
		op(4'h0, -1, 12'h000);
		$display("test carry chain done");
		complete_run();
	end
endmodule // rsc_counter_test
`default_nettype wire
